// File: servo_mode_map.vh
// constants for the servo positioner mode logic
`ifndef SERVO_MODE_MAP_VH
`define SERVO_MODE_MAP_VH
// running mode codes
`define MODE_PLAIN        3'h0
`define MODE_POINT        3'h1
`define MODE_STEP         3'h2
`define MODE_POINT_READ   3'h3
`define MODE_STEP_READ    3'h4
`define MODE_TEST         3'h5
`define MODE_REMOTE       3'h6
// phasing
`define STEPS_PER_PAIR    8'h06
`define PHASE_STEP_CYC    16'h0fa0
// counts per turn limits
`define CPT_MIN           15'h0080
`define CPT_MAX           15'h4000
// axis travel limit, 8000000 counts
`define AXIS_MAX          24'h7a1200
`define AXIS_MIN          24'h85ee00
// tables
`define POINT_COUNT       4'hf
`define STEP_COUNT        3'h7
`define AUX_DEPTH         5'h10
// test generator times in ms
`define RAMP_MAX_MS       12'h7d0
`define DWELL_MIN_MS      12'h014
`define DWELL_MAX_MS      12'h7d0
// 40 MHz clock: cycles per ms
`define CYC_PER_MS        16'h9c40
// speed limits by resolution in rpm
`define RES_12            2'h0
`define RES_14            2'h1
`define RES_16            2'h2
`define RPM_MAX_12        16'h3840
`define RPM_MAX_14        16'h0e10
`define RPM_MAX_16        16'h0384
`endif

// File: test_wave_gen.v
// test wave-form speed profile generator
`timescale 1ns/1ps
`include "servo_mode_map.vh"
module test_wave_gen (
  input  wire        i_clk_sys,   // system clock
  input  wire        i_srst,      // sync reset
  input  wire        i_run,       // start/stop enable
  input  wire [11:0] i_ramp_ms,   // ramp time
  input  wire [11:0] i_dwell_ms,  // dwell time
  input  wire [15:0] i_speed,     // target speed, clamped
  output reg  [15:0] o_ref        // speed reference
);
  localparam ST_IDLE = 2'h0;
  localparam ST_UP   = 2'h1;
  localparam ST_HOLD = 2'h2;
  localparam ST_DOWN = 2'h3;
  reg [1:0]  state_r;
  reg [15:0] ms_div_r;
  reg [11:0] ms_cnt_r;
  wire       ms_tick;
  wire [11:0] ramp_lim;
  wire [11:0] dwell_lim;
  wire [27:0] scaled;
  wire [27:0] quot;
  assign ms_tick   = (ms_div_r == `CYC_PER_MS - 16'h0001);
  assign ramp_lim  = (i_ramp_ms > `RAMP_MAX_MS) ? `RAMP_MAX_MS : i_ramp_ms;
  assign dwell_lim = (i_dwell_ms < `DWELL_MIN_MS) ? `DWELL_MIN_MS :
                     (i_dwell_ms > `DWELL_MAX_MS) ? `DWELL_MAX_MS : i_dwell_ms;
  assign scaled    = i_speed * ms_cnt_r;
  assign quot      = scaled / {16'h0000, ramp_lim};
  // profile sequencer: up, hold, down, repeat
  always @(posedge i_clk_sys) begin
    if (i_srst || !i_run) begin
      state_r  <= ST_IDLE;
      ms_div_r <= 16'h0000;
      ms_cnt_r <= 12'h000;
      o_ref    <= 16'h0000;
    end else begin
      ms_div_r <= ms_tick ? 16'h0000 : ms_div_r + 16'h0001;
      case (state_r)
        ST_IDLE: begin
          state_r  <= ST_UP;
          ms_cnt_r <= 12'h000;
        end
        ST_UP: begin
          if (ramp_lim == 12'h000) begin
            o_ref    <= i_speed;
            state_r  <= ST_HOLD;
            ms_cnt_r <= 12'h000;
          end else if (ms_tick) begin
            if (ms_cnt_r == ramp_lim) begin
              o_ref    <= i_speed;
              state_r  <= ST_HOLD;
              ms_cnt_r <= 12'h000;
            end else begin
              ms_cnt_r <= ms_cnt_r + 12'h001;
              o_ref    <= quot[15:0];
            end
          end
        end
        ST_HOLD: begin
          if (ms_tick) begin
            if (ms_cnt_r == dwell_lim) begin
              state_r  <= ST_DOWN;
              ms_cnt_r <= 12'h000;
            end else begin
              ms_cnt_r <= ms_cnt_r + 12'h001;
            end
          end
        end
        default: begin
          if (ramp_lim == 12'h000 || (ms_tick && ms_cnt_r == ramp_lim)) begin
            o_ref    <= 16'h0000;
            state_r  <= ST_UP;
            ms_cnt_r <= 12'h000;
          end else if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 12'h001;
            o_ref    <= i_speed - quot[15:0];
          end
        end
      endcase
    end
  end
endmodule

// File: aux_param_table.v
// auxiliary user parameter table with flash store sequencing
`timescale 1ns/1ps
`include "servo_mode_map.vh"
module aux_param_table (
  input  wire        i_clk_sys,     // system clock
  input  wire        i_srst,        // sync reset
  input  wire        i_wr,          // write strobe
  input  wire [3:0]  i_addr,        // entry index
  input  wire [15:0] i_wdata,       // write data
  output wire [15:0] o_rdata,       // read data
  input  wire        i_store,       // store pulse
  input  wire        i_flash_ack,   // flash accepted word
  output reg         o_flash_wr,    // flash write request
  output reg  [3:0]  o_flash_addr,  // flash word index
  output reg  [15:0] o_flash_data,  // flash word
  output reg         o_busy         // store in progress
);
  reg [15:0] mem_r [0:15];
  reg [3:0]  idx_r;
  integer    k;
  assign o_rdata = mem_r[i_addr];
  // table writes kept apart from operating table
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (k = 0; k < 16; k = k + 1) begin
        mem_r[k] <= 16'h0000;
      end
    end else if (i_wr && !o_busy) begin
      mem_r[i_addr] <= i_wdata;
    end
  end
  // store walks every entry into flash
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_busy       <= 1'b0;
      o_flash_wr   <= 1'b0;
      o_flash_addr <= 4'h0;
      o_flash_data <= 16'h0000;
      idx_r        <= 4'h0;
    end else if (!o_busy) begin
      if (i_store) begin
        o_busy       <= 1'b1;
        o_flash_wr   <= 1'b1;
        idx_r        <= 4'h0;
        o_flash_addr <= 4'h0;
        o_flash_data <= mem_r[0];
      end
    end else if (i_flash_ack) begin
      if (idx_r == 4'hf) begin
        o_busy     <= 1'b0;
        o_flash_wr <= 1'b0;
      end else begin
        idx_r        <= idx_r + 4'h1;
        o_flash_addr <= idx_r + 4'h1;
        o_flash_data <= mem_r[idx_r + 4'h1];
      end
    end
  end
endmodule

// File: servo_positioner_mode_logic.v
// operating mode and positioner logic of the servo drive
`timescale 1ns/1ps
`include "servo_mode_map.vh"
//
// Overview of operation
// - auto phasing end applies offset to resolver angle; software may overwrite
// - phasing runs six steps per motor pole pair
// - turn count is signed and cleared at every index pulse
// - count rises on clockwise rotation with correct wiring
// - seven selectable running modes
// - fifteen target points selected by four input code
// - seven step moves selected by three input code
// - no program move before homing completes
// - target held within one count
// - counts per turn kept between 128 and 16384
// - axis count spans plus or minus eight million
// - rotary step axis cleared when input 4 proximity activates
// - remote sends motion commands; drive reports position and busy
// - remote move uses parameters carried with that order
// - test generator replaces external reference
// - ramp time 0 to 2000 ms, zero gives a step
// - dwell 20 to 2000 ms sets the test period
// - target speed limit depends on resolution
// - generator runs only while enabled
// - auxiliary table holds test calibrations separately
// - store command writes auxiliary table into flash
module servo_positioner_mode_logic (
  input  wire        i_clk_sys,        // 40 MHz clock
  input  wire        i_srst,           // sync reset
  input  wire [2:0]  i_mode,           // running mode select
  input  wire        i_phase_start,    // start auto phasing
  input  wire [3:0]  i_pole_pairs,     // pole pairs
  input  wire [9:0]  i_phase_meas,     // measured phase error
  input  wire        i_offset_wr,      // software offset write
  input  wire [9:0]  i_offset_val,     // software offset value
  input  wire        i_enc_up,         // encoder count up pulse
  input  wire        i_enc_dn,         // encoder count down pulse
  input  wire        i_enc_index,      // zero index pulse
  input  wire [14:0] i_cpt,            // counts per turn setting
  input  wire [4:0]  i_dig_in,         // digital inputs 1..5
  input  wire        i_rotary,         // rotary axis
  input  wire        i_home_done,      // homing complete pulse
  input  wire        i_tbl_wr,         // point/step table write
  input  wire [3:0]  i_tbl_idx,        // table index
  input  wire [23:0] i_tbl_val,        // table value
  input  wire        i_rem_move,       // remote move order
  input  wire [23:0] i_rem_target,     // remote target
  input  wire [15:0] i_rem_speed,      // remote speed
  input  wire [15:0] i_rem_accel,      // remote accel/decel
  input  wire        i_rem_zero,       // remote zero-axis order
  input  wire [15:0] i_ext_ref,        // external reference
  input  wire [11:0] i_ramp_ms,        // test ramp time
  input  wire [11:0] i_dwell_ms,       // test dwell time
  input  wire [15:0] i_test_speed,     // test target speed
  input  wire [1:0]  i_res_sel,        // resolution select
  input  wire        i_test_run,       // test start/stop
  input  wire        i_aux_wr,         // aux table write
  input  wire [3:0]  i_aux_addr,       // aux address
  input  wire [15:0] i_aux_wdata,      // aux data
  input  wire        i_aux_store,      // store aux table
  input  wire        i_flash_ack,      // flash word accepted
  output reg  [15:0] o_aux_rdata,      // aux read data
  output reg         o_flash_wr,       // flash write request
  output reg  [3:0]  o_flash_addr,     // flash address
  output reg  [15:0] o_flash_data,     // flash data
  output reg         o_aux_busy,       // store busy
  output reg  [9:0]  o_phase_offset,   // resolver angle offset
  output reg         o_phase_done,     // phasing done
  output reg  [7:0]  o_phase_step,     // current phasing step
  output reg  [15:0] o_turn_count,     // signed count in turn
  output reg  [23:0] o_axis_pos,       // signed axis position
  output reg  [23:0] o_target,         // active target
  output reg  [15:0] o_move_speed,     // active move speed
  output reg  [15:0] o_move_accel,     // active move accel
  output reg         o_busy,           // move in progress
  output reg         o_refused,        // move refused, not homed
  output reg         o_homed,          // zero axis done
  output reg         o_zero_req,       // zero axis requested
  output reg  [15:0] o_ref,            // reference to loops
  output reg  [2:0]  o_mode            // active mode
);

  // ------------------
  // state and storage
  // ------------------
  localparam PH_IDLE = 2'h0;
  localparam PH_STEP = 2'h1;
  localparam PH_DONE = 2'h2;

  reg [1:0]  ph_state_r;
  reg [15:0] ph_tmr_r;
  reg [7:0]  ph_total_r;
  reg [23:0] pt_tbl_r [0:15];
  reg [23:0] st_tbl_r [0:7];
  reg [4:0]  dig_prev_r;
  reg        prox_prev_r;
  reg [14:0] cpt_r;

  wire [15:0] gen_ref;
  wire [15:0] aux_rdata;
  wire        flash_wr;
  wire [3:0]  flash_addr;
  wire [15:0] flash_data;
  wire        aux_busy;
  wire [15:0] spd_clamped;
  wire [15:0] spd_lim;
  wire [3:0]  pt_code;
  wire [2:0]  st_code;
  wire        pos_mode;
  wire [23:0] pos_nxt;
  wire [23:0] step_nxt;
  wire [24:0] step_sum;
  wire [24:0] err;
  integer     j;

  // ------------------
  // test generator and auxiliary table
  // ------------------
  // speed ceiling by resolution
  assign spd_lim = (i_res_sel == `RES_12) ? `RPM_MAX_12 :
                   (i_res_sel == `RES_14) ? `RPM_MAX_14 : `RPM_MAX_16;
  assign spd_clamped = (i_test_speed > spd_lim) ? spd_lim : i_test_speed;
  test_wave_gen u_gen (
    .i_clk_sys  (i_clk_sys),
    .i_srst     (i_srst),
    .i_run      (i_test_run && (o_mode == `MODE_TEST)),
    .i_ramp_ms  (i_ramp_ms),
    .i_dwell_ms (i_dwell_ms),
    .i_speed    (spd_clamped),
    .o_ref      (gen_ref)
  );

  aux_param_table u_aux (
    .i_clk_sys    (i_clk_sys),
    .i_srst       (i_srst),
    .i_wr         (i_aux_wr),
    .i_addr       (i_aux_addr),
    .i_wdata      (i_aux_wdata),
    .o_rdata      (aux_rdata),
    .i_store      (i_aux_store),
    .i_flash_ack  (i_flash_ack),
    .o_flash_wr   (flash_wr),
    .o_flash_addr (flash_addr),
    .o_flash_data (flash_data),
    .o_busy       (aux_busy)
  );

  // registered copies of submodule outputs and the selected reference
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_aux_rdata  <= 16'h0000;
      o_flash_wr   <= 1'b0;
      o_flash_addr <= 4'h0;
      o_flash_data <= 16'h0000;
      o_aux_busy   <= 1'b0;
      o_ref        <= 16'h0000;
    end else begin
      o_aux_rdata  <= aux_rdata;
      o_flash_wr   <= flash_wr;
      o_flash_addr <= flash_addr;
      o_flash_data <= flash_data;
      o_aux_busy   <= aux_busy;
      o_ref        <= (o_mode == `MODE_TEST) ? gen_ref : i_ext_ref;
    end
  end

  // ------------------
  // mode select and counts per turn
  // ------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_mode <= `MODE_PLAIN;
      cpt_r  <= `CPT_MIN;
    end else begin
      if (i_mode <= `MODE_REMOTE) begin
        o_mode <= i_mode;
      end
      cpt_r <= (i_cpt < `CPT_MIN) ? `CPT_MIN :
               (i_cpt > `CPT_MAX) ? `CPT_MAX : i_cpt;
    end
  end

  // ------------------
  // automatic resolver phasing
  // ------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      ph_state_r     <= PH_IDLE;
      ph_tmr_r       <= 16'h0000;
      ph_total_r     <= 8'h00;
      o_phase_step   <= 8'h00;
      o_phase_done   <= 1'b0;
      o_phase_offset <= 10'h000;
    end else begin
      case (ph_state_r)
        PH_IDLE: begin
          if (i_phase_start) begin
            ph_total_r   <= `STEPS_PER_PAIR * {4'h0, i_pole_pairs};
            o_phase_step <= 8'h00;
            ph_tmr_r     <= 16'h0000;
            o_phase_done <= 1'b0;
            ph_state_r   <= PH_STEP;
          end
        end
        PH_STEP: begin
          if (ph_tmr_r == `PHASE_STEP_CYC) begin
            ph_tmr_r <= 16'h0000;
            if (o_phase_step + 8'h01 >= ph_total_r) begin
              o_phase_step <= o_phase_step + 8'h01;
              ph_state_r   <= PH_DONE;
            end else begin
              o_phase_step <= o_phase_step + 8'h01;
            end
          end else begin
            ph_tmr_r <= ph_tmr_r + 16'h0001;
          end
        end
        default: begin
          o_phase_offset <= 10'h000 - i_phase_meas;
          o_phase_done   <= 1'b1;
          ph_state_r     <= PH_IDLE;
        end
      endcase
      if (i_offset_wr && ph_state_r != PH_DONE) begin
        o_phase_offset <= i_offset_val;
      end
    end
  end

  // ------------------
  // turn count and axis position
  // ------------------
  assign pos_nxt = o_axis_pos + (i_enc_up ? 24'h000001 : 24'h000000)
                              - (i_enc_dn ? 24'h000001 : 24'h000000);
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_turn_count <= 16'h0000;
      o_axis_pos   <= 24'h000000;
      prox_prev_r  <= 1'b0;
    end else begin
      prox_prev_r <= i_dig_in[3];
      if (i_enc_index) begin
        o_turn_count <= 16'h0000;
      end else if (i_enc_up && !i_enc_dn) begin
        o_turn_count <= o_turn_count + 16'h0001;
      end else if (i_enc_dn && !i_enc_up) begin
        o_turn_count <= o_turn_count - 16'h0001;
      end
      if (i_home_done) begin
        o_axis_pos <= 24'h000000;
      end else if (i_rotary && o_mode == `MODE_STEP && i_dig_in[3] && !prox_prev_r) begin
        o_axis_pos <= 24'h000000;
      end else if (i_enc_up && !i_enc_dn && o_axis_pos != `AXIS_MAX) begin
        o_axis_pos <= pos_nxt;
      end else if (i_enc_dn && !i_enc_up && o_axis_pos != `AXIS_MIN) begin
        o_axis_pos <= pos_nxt;
      end
    end
  end

  // ------------------
  // point and step tables
  // ------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (j = 0; j < 16; j = j + 1) begin
        pt_tbl_r[j] <= 24'h000000;
      end
      for (j = 0; j < 8; j = j + 1) begin
        st_tbl_r[j] <= 24'h000000;
      end
    end else if (i_tbl_wr) begin
      if (o_mode == `MODE_STEP || o_mode == `MODE_STEP_READ) begin
        st_tbl_r[i_tbl_idx[2:0]] <= i_tbl_val;
      end else begin
        pt_tbl_r[i_tbl_idx] <= i_tbl_val;
      end
    end
  end

  // ------------------
  // positioner sequencing
  // ------------------
  assign pt_code  = i_dig_in[3:0];
  assign st_code  = i_dig_in[2:0];
  assign pos_mode = (o_mode == `MODE_POINT) || (o_mode == `MODE_STEP) ||
                    (o_mode == `MODE_REMOTE);
  assign step_sum = {o_target[23], o_target} + {st_tbl_r[st_code][23], st_tbl_r[st_code]};
  assign step_nxt = step_sum[23:0];
  assign err      = {o_target[23], o_target} - {o_axis_pos[23], o_axis_pos};
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_target     <= 24'h000000;
      o_move_speed <= 16'h0000;
      o_move_accel <= 16'h0000;
      o_busy       <= 1'b0;
      o_refused    <= 1'b0;
      o_homed      <= 1'b0;
      o_zero_req   <= 1'b0;
      dig_prev_r   <= 5'h00;
    end else begin
      dig_prev_r <= i_dig_in;
      o_refused  <= 1'b0;
      o_zero_req <= i_rem_zero && (o_mode == `MODE_REMOTE);
      if (i_home_done) begin
        o_homed <= 1'b1;
      end

      // settled once within one count of target
      if (o_busy && (err == 25'h0000000 || err == 25'h0000001 ||
                     err == 25'h1ffffff)) begin
        o_busy <= 1'b0;
      end
      if (o_mode == `MODE_POINT && i_dig_in[4] && !dig_prev_r[4] && pt_code != 4'h0) begin
        if (!o_homed) begin
          o_refused <= 1'b1;
        end else begin
          o_target <= pt_tbl_r[pt_code];
          o_busy   <= 1'b1;
        end
      end else if (o_mode == `MODE_STEP && i_dig_in[4] && !dig_prev_r[4] &&
                   st_code != 3'h0) begin
        if (!o_homed) begin
          o_refused <= 1'b1;
        end else begin
          o_target <= step_nxt;
          o_busy   <= 1'b1;
        end
      end else if (o_mode == `MODE_REMOTE && i_rem_move) begin
        if (!o_homed) begin
          o_refused <= 1'b1;
        end else begin
          o_target     <= i_rem_target;
          o_move_speed <= i_rem_speed;
          o_move_accel <= i_rem_accel;
          o_busy       <= 1'b1;
        end
      end else if (!pos_mode) begin
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// File: servo_mode_props.sv
// assertion checker bound to the servo mode logic
`timescale 1ns/1ps
module servo_mode_props (
  input wire        i_clk_sys, i_srst, i_home_done, i_enc_up, i_enc_dn, // control inputs
  input wire        i_enc_index, i_rem_move, i_test_run, i_phase_start, // control inputs
  input wire        i_offset_wr, i_flash_ack, o_refused, o_homed,       // flags
  input wire        o_phase_done, o_flash_wr, o_busy,                   // flags
  input wire [2:0]  i_mode, o_mode,                                     // mode select
  input wire [4:0]  i_dig_in,                                           // digital inputs
  input wire [9:0]  i_phase_meas, i_offset_val, o_phase_offset,         // phase angle
  input wire [23:0] i_rem_target, o_target, o_axis_pos,                 // positions
  input wire [15:0] i_rem_speed, i_rem_accel, o_move_speed, o_move_accel, // motion
  input wire [15:0] o_turn_count, o_ref, o_flash_data,                  // counts, data
  input wire [3:0]  o_flash_addr                                        // flash index
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_exec_unhomed;
    $rose(i_dig_in[4]) && !i_home_done && !o_homed &&
      (o_mode == 3'h1 && i_dig_in[3:0] != 4'h0 || o_mode == 3'h2 && i_dig_in[2:0] != 3'h0);
  endsequence
  sequence s_test_stopped;
    (i_mode == 3'h5 && !i_test_run) [*4];
  endsequence
  sequence s_flash_waiting;
    o_flash_wr && !i_flash_ack && !$past(i_flash_ack);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_refuse_unhomed: assert property (s_exec_unhomed |=> o_refused && !o_busy)
    else $error("move taken before homing");
  a_refuse_pulse: assert property (o_refused |=> !o_refused)
    else $error("refusal longer than one cycle");
  a_index_clear: assert property (i_enc_index |=> o_turn_count == 16'h0)
    else $error("index did not clear turn count");
  a_count_up: assert property (i_enc_up && !i_enc_dn && !i_enc_index && o_turn_count < 16'h0040
    |=> o_turn_count == $past(o_turn_count) + 16'h1)
    else $error("turn count did not rise");
  a_home_zero: assert property (i_home_done |=> o_homed && o_axis_pos == 24'h0)
    else $error("homing did not zero axis");
  a_remote_load: assert property (o_mode == 3'h6 && i_rem_move && o_homed |=>
    o_target == $past(i_rem_target) && o_move_speed == $past(i_rem_speed)
    && o_move_accel == $past(i_rem_accel))
    else $error("remote move parameters not taken");
  a_test_stop: assert property (s_test_stopped |=> o_ref == 16'h0)
    else $error("test reference not halted");
  a_phase_hold: assert property (o_phase_done && !i_phase_start |=> o_phase_done)
    else $error("phasing done dropped");
  a_phase_offset: assert property ($rose(o_phase_done) |->
    o_phase_offset == 10'h0 - $past(i_phase_meas))
    else $error("phasing offset wrong");
  a_offset_write: assert property (i_offset_wr && o_phase_done
    |=> o_phase_offset == $past(i_offset_val))
    else $error("offset write lost");
  a_flash_hold: assert property (s_flash_waiting |=> o_flash_wr && $stable(o_flash_addr)
    && $stable(o_flash_data))
    else $error("flash request changed before ack");
endmodule
bind servo_positioner_mode_logic servo_mode_props props_u (.*);

// File: flash_word_model.sv
// flash memory model answering the aux table store stream
`timescale 1ns/1ps
module flash_word_model #(parameter int DLY = 3) (
  input  wire        i_clk_sys, // clock
  input  wire        i_wr,      // write request
  input  wire [3:0]  i_addr,    // word index
  input  wire [15:0] i_data,    // word
  output logic       o_ack      // word accepted
);
  logic [15:0] mem [0:15];
  int          wait_cnt = 0;
  initial o_ack = 1'b0;
  // program delay before each one-cycle ack, so a stalled store is exercised
  always @(posedge i_clk_sys) begin
    o_ack <= 1'b0;
    if (i_wr && !o_ack && wait_cnt >= DLY) begin
      mem[i_addr] <= i_data;
      o_ack       <= 1'b1;
      wait_cnt    <= 0;
    end else if (i_wr && !o_ack) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// File: tb_servo_positioner_mode_logic.sv
// self-checking bench for the servo mode logic
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_servo_positioner_mode_logic;
  logic        i_clk_sys = 1'b0, i_srst = 1'b1, i_phase_start = 1'b0, i_offset_wr = 1'b0;
  logic        i_enc_up = 1'b0, i_enc_dn = 1'b0, i_enc_index = 1'b0, i_rotary = 1'b0;
  logic        i_home_done = 1'b0, i_tbl_wr = 1'b0, i_rem_move = 1'b0, i_rem_zero = 1'b0;
  logic        i_test_run = 1'b0, i_aux_wr = 1'b0, i_aux_store = 1'b0, ref_seen = 1'b0;
  logic [2:0]  i_mode = 3'h0;
  logic [3:0]  i_pole_pairs = 4'h1, i_tbl_idx = 4'h0, i_aux_addr = 4'h0;
  logic [4:0]  i_dig_in = 5'h00;
  logic [9:0]  i_phase_meas = 10'h011, i_offset_val = 10'h000;
  logic [11:0] i_ramp_ms = 12'h000;
  logic [15:0] i_rem_speed = 16'h0, i_rem_accel = 16'h0, i_ext_ref = 16'h0, i_test_speed = 16'h0;
  logic [15:0] i_aux_wdata = 16'h0;
  logic [23:0] i_tbl_val = 24'h0, i_rem_target = 24'h0;
  wire         i_flash_ack, o_flash_wr, o_aux_busy, o_phase_done, o_busy, o_refused, o_homed;
  wire  [3:0]  o_flash_addr;
  wire  [9:0]  o_phase_offset;
  wire  [15:0] o_aux_rdata, o_flash_data, o_turn_count, o_move_speed, o_move_accel, o_ref;
  wire  [23:0] o_axis_pos, o_target;
  wire  [2:0]  o_mode;
  wire  [7:0]  o_phase_step;
  wire         o_zero_req;
  int          err_count = 0, cmp_count = 0, cyc = 0, n;
  // ----------------------------------------
  // clock, design and flash model
  // ----------------------------------------
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  servo_positioner_mode_logic dut_u (.*, .i_cpt(15'h0400), .i_dwell_ms(12'h014),
    .i_res_sel(2'h2));
  flash_word_model #(.DLY(3)) flash_u (.i_clk_sys, .i_wr(o_flash_wr), .i_addr(o_flash_addr),
    .i_data(o_flash_data), .o_ack(i_flash_ack));
  // refusal pulse catcher and hang limit
  always @(posedge i_clk_sys) begin
    if (o_refused === 1'b1) ref_seen <= 1'b1;
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  task tick(input int k);
    repeat (k) @(negedge i_clk_sys);
  endtask
  task exec(input logic [4:0] code);
    i_dig_in = code;
    tick(1);
    i_dig_in = code | 5'h10;
    tick(3);
    i_dig_in = 5'h00;
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    tick(16);
    i_srst = 1'b0;
    `CHK(o_homed, 1'b0)
    for (int m = 0; m < 7; m++) begin
      i_mode = m[2:0];
      tick(3);
      `CHK(o_mode, m[2:0])
    end
    i_mode = 3'h0;
    i_ext_ref = 16'h1234;
    tick(4);
    `CHK(o_ref, 16'h1234)
    $display("test modes done");
    i_mode = 3'h1;
    exec(5'h02);
    `CHK(ref_seen, 1'b1)
    `CHK(o_busy, 1'b0)
    i_home_done = 1'b1;
    tick(1);
    i_home_done = 1'b0;
    tick(2);
    `CHK(o_homed, 1'b1)
    `CHK(o_axis_pos, 24'h0)
    {i_tbl_wr, i_tbl_idx, i_tbl_val} = {1'b1, 4'h2, 24'h000020};
    tick(1);
    i_tbl_wr = 1'b0;
    exec(5'h02);
    `CHK(o_target, 24'h000020)
    `CHK(o_busy, 1'b1)
    i_mode = 3'h2;
    tick(2);
    {i_tbl_wr, i_tbl_idx, i_tbl_val} = {1'b1, 4'h1, 24'h000005};
    tick(1);
    i_tbl_wr = 1'b0;
    exec(5'h01);
    `CHK(o_target, 24'h000025)
    $display("test positioner done");
    i_mode = 3'h6;
    {i_rem_target, i_rem_speed, i_rem_accel, i_rem_zero} = {24'h10, 16'h0200, 16'h0030, 1'b1};
    tick(2);
    i_rem_move = 1'b1;
    tick(1);
    i_rem_move = 1'b0;
    tick(2);
    `CHK({o_target, o_move_speed, o_move_accel}, {24'h10, 16'h0200, 16'h0030})
    `CHK({o_busy, o_zero_req}, 2'h3)
    i_enc_up = 1'b1;
    tick(15);
    i_enc_up = 1'b0;
    tick(3);
    `CHK(o_axis_pos, 24'h00000f)
    `CHK(o_turn_count, 16'h000f)
    `CHK(o_busy, 1'b0)
    i_enc_index = 1'b1;
    tick(1);
    i_enc_index = 1'b0;
    tick(2);
    `CHK(o_turn_count, 16'h0000)
    i_enc_dn = 1'b1;
    tick(2);
    i_enc_dn = 1'b0;
    tick(2);
    `CHK(o_turn_count, 16'hfffe)
    i_mode = 3'h2;
    i_rotary = 1'b1;
    tick(2);
    i_dig_in = 5'h08;
    tick(3);
    `CHK(o_axis_pos, 24'h0)
    i_dig_in = 5'h00;
    $display("test remote and counts done");
    i_phase_start = 1'b1;
    tick(1);
    i_phase_start = 1'b0;
    n = 0;
    while (o_phase_done !== 1'b1 && n < 30000) begin
      tick(1);
      n++;
    end
    `CHK(n >= 24000 && n <= 24012, 1'b1)
    `CHK(o_phase_offset, 10'h3ef)
    `CHK(o_phase_step, 8'h06)
    {i_offset_wr, i_offset_val} = {1'b1, 10'h123};
    tick(1);
    i_offset_wr = 1'b0;
    tick(2);
    `CHK(o_phase_offset, 10'h123)
    $display("test phasing done");
    {i_mode, i_test_speed, i_test_run} = {3'h5, 16'h1000, 1'b1};
    n = 0;
    while (o_ref !== 16'h0384 && n < 20) begin
      tick(1);
      n++;
    end
    `CHK(o_ref, 16'h0384)
    i_test_run = 1'b0;
    tick(5);
    `CHK(o_ref, 16'h0000)
    {i_ramp_ms, i_test_run} = {12'h001, 1'b1};
    tick(100);
    `CHK(o_ref < 16'h0384, 1'b1)
    i_test_run = 1'b0;
    $display("test generator done");
    for (int a = 0; a < 16; a++) begin
      {i_aux_wr, i_aux_addr, i_aux_wdata} = {1'b1, a[3:0], 16'ha000 + a[15:0]};
      tick(1);
    end
    {i_aux_wr, i_aux_addr} = {1'b0, 4'h3};
    tick(2);
    `CHK(o_aux_rdata, 16'ha003)
    `CHK(o_target, 24'h10)
    i_aux_store = 1'b1;
    tick(1);
    i_aux_store = 1'b0;
    n = 0;
    while ((o_aux_busy === 1'b1 || n < 4) && n < 1000) begin
      tick(1);
      n++;
    end
    for (int a = 0; a < 16; a++) `CHK(flash_u.mem[a], 16'ha000 + a[15:0])
    $display("test aux table done");
    summarize();
  end
endmodule
